// ---- include/rxc_consts.vh ----
// constants for the receive converter calibration register bank
`ifndef RXC_CONSTS_VH
`define RXC_CONSTS_VH

// register indices (printed offsets are not all multiples of four,
// so each printed offset is an index and the byte address is index * 4)
`define RXC_IDX_FSADJ      8'h7D
`define RXC_IDX_TRIMCTRL   8'h7E
`define RXC_IDX_IHIGH      8'h7F
`define RXC_IDX_ILOW       8'h80
`define RXC_IDX_QHIGH      8'h81
`define RXC_IDX_QLOW       8'h82
`define RXC_IDX_LOCK       8'h84
`define RXC_IDX_PWRCTRL    8'h90
`define RXC_IDX_IRQSTAT    8'h91
`define RXC_IDX_IRQMASK    8'h92
`define RXC_IDX_TRIGGER    8'hFF

// field positions
`define RXC_BIT_BUF_OFF    0
`define RXC_BIT_FINE       5
`define RXC_BIT_CAL_EN     6
`define RXC_BIT_CONV_EN    0
`define RXC_BIT_RX_LOCK    0
`define RXC_BIT_TX_LOCK    1
`define RXC_BIT_UPDATE     0
`define RXC_BIT_PD_Q       0
`define RXC_BIT_SINGLE     1

// interrupt status bits
`define RXC_IRQ_XFER       0
`define RXC_IRQ_RX_LOST    1
`define RXC_IRQ_TX_LOST    2
`define RXC_IRQ_W          3

// reset values
`define RXC_RST_BYTE       8'h00
`define RXC_RST_TRIM       10'h000

// axi responses
`define RXC_RESP_OKAY      2'b00
`define RXC_RESP_SLVERR    2'b10

`endif

// ---- core/rxc_sync2.v ----
// two flip-flop synchroniser for asynchronous level inputs
`timescale 1ns/1ps
`default_nettype none

module rxc_sync2 #(
    parameter W = 2
) (
    input  wire         clk_in,
    input  wire         sys_rst_in,
    input  wire [W-1:0] async_in,
    output reg  [W-1:0] sync_out
);

    reg [W-1:0] meta_r;

    // first stage feeds only the second
    always @(posedge clk_in or posedge sys_rst_in)
    begin
        if (sys_rst_in)
        begin
            meta_r   <= {W{1'b0}};
            sync_out <= {W{1'b0}};
        end
        else
        begin
            meta_r   <= async_in;
            sync_out <= meta_r;
        end
    end

endmodule // rxc_sync2

`default_nettype wire

// ---- core/rxc_regs.v ----
// receive converter calibration register bank with axi4-lite slave
//
// The AXI4-Lite interface to the registers was left to the implementer.
`timescale 1ns/1ps
`default_nettype none
`include "rxc_consts.vh"

module rxc_regs (
    input  wire        clk_in,
    input  wire        sys_rst_in,
    // axi4-lite write address
    input  wire [11:0] s_axi_awaddr_in,
    input  wire        s_axi_awvalid_in,
    output reg         s_axi_awready_out,
    // axi4-lite write data
    input  wire [31:0] s_axi_wdata_in,
    input  wire [3:0]  s_axi_wstrb_in,
    input  wire        s_axi_wvalid_in,
    output reg         s_axi_wready_out,
    // axi4-lite write response
    output reg  [1:0]  s_axi_bresp_out,
    output reg         s_axi_bvalid_out,
    input  wire        s_axi_bready_in,
    // axi4-lite read address
    input  wire [11:0] s_axi_araddr_in,
    input  wire        s_axi_arvalid_in,
    output reg         s_axi_arready_out,
    // axi4-lite read data
    output reg  [31:0] s_axi_rdata_out,
    output reg  [1:0]  s_axi_rresp_out,
    output reg         s_axi_rvalid_out,
    input  wire        s_axi_rready_in,
    // loop lock pins, asynchronous
    input  wire        tx_loop_lock_in,
    input  wire        rx_loop_lock_in,
    // local (active) converter settings, then the interrupt output
    output reg  [9:0]  i_channel_gain_trim_out,
    output reg  [9:0]  q_channel_gain_trim_out,
    output reg         fine_trim_option_out,
    output reg         i_calibration_converter_enable_out,
    output reg         q_calibration_converter_enable_out,
    output reg         input_bias_buffer_off_out,
    output reg  [4:0]  full_scale_adjust_out,
    output reg         q_converter_power_down_out,
    output reg         single_converter_mode_out,
    output reg         irq_out
);

    // ****************************************************************
    // decode
    // ****************************************************************

    // byte address to register index; misaligned or high index gives ff+1
    function [8:0] idx_of;
        input [11:0] addr;
        begin
            if (addr[1:0] != 2'b00 || addr[11:10] != 2'b00)
                idx_of = 9'h100;
            else
                idx_of = {1'b0, addr[9:2]};
        end
    endfunction

    function mapped;
        input [8:0] idx;
        begin
            case (idx)
                {1'b0, `RXC_IDX_FSADJ},   {1'b0, `RXC_IDX_TRIMCTRL},
                {1'b0, `RXC_IDX_IHIGH},   {1'b0, `RXC_IDX_ILOW},
                {1'b0, `RXC_IDX_QHIGH},   {1'b0, `RXC_IDX_QLOW},
                {1'b0, `RXC_IDX_LOCK},    {1'b0, `RXC_IDX_PWRCTRL},
                {1'b0, `RXC_IDX_IRQSTAT}, {1'b0, `RXC_IDX_IRQMASK},
                {1'b0, `RXC_IDX_TRIGGER}:
                    mapped = 1'b1;
                default:
                    mapped = 1'b0;
            endcase
        end
    endfunction

    // ****************************************************************
    // global register set
    // ****************************************************************

    reg  [7:0] fsadj_r;
    reg  [7:0] trimctrl_r;
    reg  [7:0] ihigh_r;
    reg  [7:0] ilow_r;
    reg  [7:0] qhigh_r;
    reg  [7:0] qlow_r;
    reg  [7:0] pwrctrl_r;
    reg  [7:0] trig_r;
    reg        trig_prev_r;
    reg  [`RXC_IRQ_W-1:0] irq_stat_r;
    reg  [`RXC_IRQ_W-1:0] irq_mask_r;
    reg  [`RXC_IRQ_W-1:0] irq_stat_nxt;
    reg  [1:0] lock_prev_r;

    wire [1:0] lock_sync;
    wire       xfer_pulse;
    wire [9:0] i_trim_glb;
    wire [9:0] q_trim_glb;
    wire       cal_en_glb;

    // loop lock pins come from another domain
    rxc_sync2 #(
        .W (2)
    ) u_lock_sync (
        .clk_in     (clk_in),
        .sys_rst_in (sys_rst_in),
        .async_in   ({tx_loop_lock_in, rx_loop_lock_in}),
        .sync_out   (lock_sync)
    );

    // ****************************************************************
    // write channel
    // ****************************************************************

    reg        aw_held_r;
    reg        w_held_r;
    reg [11:0] awaddr_r;
    reg [31:0] wdata_r;
    reg [3:0]  wstrb_r;

    wire       aw_take  = s_axi_awvalid_in & s_axi_awready_out;
    wire       w_take   = s_axi_wvalid_in & s_axi_wready_out;
    wire       do_write = aw_held_r & w_held_r & ~s_axi_bvalid_out;
    wire [8:0] widx     = idx_of(awaddr_r);
    wire       wlane0   = do_write & wstrb_r[0];

    // address and data taken in either order, one write in flight
    always @(posedge clk_in or posedge sys_rst_in)
    begin
        if (sys_rst_in)
        begin
            aw_held_r         <= 1'b0;
            w_held_r          <= 1'b0;
            awaddr_r          <= 12'h000;
            wdata_r           <= 32'h0000_0000;
            wstrb_r           <= 4'h0;
            s_axi_awready_out <= 1'b0;
            s_axi_wready_out  <= 1'b0;
            s_axi_bvalid_out  <= 1'b0;
            s_axi_bresp_out   <= `RXC_RESP_OKAY;
        end
        else
        begin
            s_axi_awready_out <= ~aw_held_r & ~aw_take & ~s_axi_bvalid_out;
            s_axi_wready_out  <= ~w_held_r & ~w_take & ~s_axi_bvalid_out;
            if (aw_take)
            begin
                aw_held_r <= 1'b1;
                awaddr_r  <= s_axi_awaddr_in;
            end
            if (w_take)
            begin
                w_held_r <= 1'b1;
                wdata_r  <= s_axi_wdata_in;
                wstrb_r  <= s_axi_wstrb_in;
            end
            if (do_write)
            begin
                aw_held_r        <= 1'b0;
                w_held_r         <= 1'b0;
                s_axi_bvalid_out <= 1'b1;
                s_axi_bresp_out  <= mapped(widx) ? `RXC_RESP_OKAY
                                                 : `RXC_RESP_SLVERR;
            end
            else if (s_axi_bvalid_out & s_axi_bready_in)
                s_axi_bvalid_out <= 1'b0;
        end
    end

    // register storage; only byte lane 0 carries data
    always @(posedge clk_in or posedge sys_rst_in)
    begin
        if (sys_rst_in)
        begin
            fsadj_r    <= `RXC_RST_BYTE;
            trimctrl_r <= `RXC_RST_BYTE;
            ihigh_r    <= `RXC_RST_BYTE;
            ilow_r     <= `RXC_RST_BYTE;
            qhigh_r    <= `RXC_RST_BYTE;
            qlow_r     <= `RXC_RST_BYTE;
            pwrctrl_r  <= `RXC_RST_BYTE;
            trig_r     <= `RXC_RST_BYTE;
            irq_mask_r <= {`RXC_IRQ_W{1'b0}};
        end
        else if (wlane0)
        begin
            case (widx)
                {1'b0, `RXC_IDX_FSADJ}:    fsadj_r    <= {3'b000, wdata_r[4:0]};
                {1'b0, `RXC_IDX_TRIMCTRL}: trimctrl_r <= wdata_r[7:0];
                {1'b0, `RXC_IDX_IHIGH}:    ihigh_r    <= wdata_r[7:0];
                {1'b0, `RXC_IDX_ILOW}:     ilow_r     <= {5'h00, wdata_r[2:0]};
                {1'b0, `RXC_IDX_QHIGH}:    qhigh_r    <= wdata_r[7:0];
                {1'b0, `RXC_IDX_QLOW}:     qlow_r     <= {5'h00, wdata_r[2:0]};
                {1'b0, `RXC_IDX_PWRCTRL}:  pwrctrl_r  <= {6'h00, wdata_r[1:0]};
                {1'b0, `RXC_IDX_IRQMASK}:  irq_mask_r <= wdata_r[`RXC_IRQ_W-1:0];
                {1'b0, `RXC_IDX_TRIGGER}:  trig_r     <= {7'h00, wdata_r[0]};
                default:                   trig_r     <= trig_r;
            endcase
        end
    end

    // ****************************************************************
    // transfer trigger and local register set
    // ****************************************************************

    // holding the bit at one gives no second transfer
    assign xfer_pulse = trig_r[`RXC_BIT_UPDATE] & ~trig_prev_r;

    assign i_trim_glb = {ihigh_r, ilow_r[2:1]};
    assign q_trim_glb = {qhigh_r, qlow_r[2:1]};
    assign cal_en_glb = trimctrl_r[`RXC_BIT_CAL_EN];

    always @(posedge clk_in or posedge sys_rst_in)
    begin
        if (sys_rst_in)
        begin
            trig_prev_r                        <= 1'b0;
            i_channel_gain_trim_out            <= `RXC_RST_TRIM;
            q_channel_gain_trim_out            <= `RXC_RST_TRIM;
            fine_trim_option_out               <= 1'b0;
            i_calibration_converter_enable_out <= 1'b0;
            q_calibration_converter_enable_out <= 1'b0;
            input_bias_buffer_off_out          <= 1'b0;
            full_scale_adjust_out              <= 5'h00;
            q_converter_power_down_out         <= 1'b0;
            single_converter_mode_out          <= 1'b0;
        end
        else
        begin
            trig_prev_r <= trig_r[`RXC_BIT_UPDATE];
            if (xfer_pulse)
            begin
                // trim forced to zero while calibration is disabled
                i_channel_gain_trim_out <= cal_en_glb ? i_trim_glb
                                                      : `RXC_RST_TRIM;
                q_channel_gain_trim_out <= cal_en_glb ? q_trim_glb
                                                      : `RXC_RST_TRIM;
                // downstream halves the step weight when set
                fine_trim_option_out <= trimctrl_r[`RXC_BIT_FINE];
                i_calibration_converter_enable_out
                    <= ilow_r[`RXC_BIT_CONV_EN];
                q_calibration_converter_enable_out
                    <= qlow_r[`RXC_BIT_CONV_EN];
                input_bias_buffer_off_out
                    <= trimctrl_r[`RXC_BIT_BUF_OFF];
                full_scale_adjust_out <= fsadj_r[4:0];
                q_converter_power_down_out
                    <= pwrctrl_r[`RXC_BIT_PD_Q];
                single_converter_mode_out
                    <= pwrctrl_r[`RXC_BIT_SINGLE];
            end
        end
    end

    // ****************************************************************
    // interrupts
    // ****************************************************************

    // set wins over a write-one clear in the same cycle
    always @*
    begin
        irq_stat_nxt = irq_stat_r;
        if (wlane0 && widx == {1'b0, `RXC_IDX_IRQSTAT})
            irq_stat_nxt = irq_stat_nxt & ~wdata_r[`RXC_IRQ_W-1:0];
        if (xfer_pulse)
            irq_stat_nxt[`RXC_IRQ_XFER] = 1'b1;
        if (lock_prev_r[`RXC_BIT_RX_LOCK] & ~lock_sync[`RXC_BIT_RX_LOCK])
            irq_stat_nxt[`RXC_IRQ_RX_LOST] = 1'b1;
        if (lock_prev_r[`RXC_BIT_TX_LOCK] & ~lock_sync[`RXC_BIT_TX_LOCK])
            irq_stat_nxt[`RXC_IRQ_TX_LOST] = 1'b1;
    end

    always @(posedge clk_in or posedge sys_rst_in)
    begin
        if (sys_rst_in)
        begin
            irq_stat_r  <= {`RXC_IRQ_W{1'b0}};
            lock_prev_r <= 2'b00;
            irq_out     <= 1'b0;
        end
        else
        begin
            irq_stat_r  <= irq_stat_nxt;
            lock_prev_r <= lock_sync;
            irq_out     <= |(irq_stat_nxt & irq_mask_r);
        end
    end

    // ****************************************************************
    // read channel
    // ****************************************************************

    reg  [7:0] rd_byte;
    wire [8:0] ridx   = idx_of(s_axi_araddr_in);
    wire       ar_take = s_axi_arvalid_in & s_axi_arready_out;

    always @*
    begin
        rd_byte = 8'h00;
        case (ridx)
            {1'b0, `RXC_IDX_FSADJ}:    rd_byte = fsadj_r;
            {1'b0, `RXC_IDX_TRIMCTRL}: rd_byte = trimctrl_r;
            {1'b0, `RXC_IDX_IHIGH}:    rd_byte = ihigh_r;
            {1'b0, `RXC_IDX_ILOW}:     rd_byte = ilow_r;
            {1'b0, `RXC_IDX_QHIGH}:    rd_byte = qhigh_r;
            {1'b0, `RXC_IDX_QLOW}:     rd_byte = qlow_r;
            {1'b0, `RXC_IDX_LOCK}:     rd_byte = {6'h00, lock_sync};
            {1'b0, `RXC_IDX_PWRCTRL}:  rd_byte = pwrctrl_r;
            {1'b0, `RXC_IDX_IRQSTAT}:  rd_byte = {5'h00, irq_stat_r};
            {1'b0, `RXC_IDX_IRQMASK}:  rd_byte = {5'h00, irq_mask_r};
            {1'b0, `RXC_IDX_TRIGGER}:  rd_byte = trig_r;
            default:                   rd_byte = 8'h00;
        endcase
    end

    always @(posedge clk_in or posedge sys_rst_in)
    begin
        if (sys_rst_in)
        begin
            s_axi_arready_out <= 1'b0;
            s_axi_rvalid_out  <= 1'b0;
            s_axi_rdata_out   <= 32'h0000_0000;
            s_axi_rresp_out   <= `RXC_RESP_OKAY;
        end
        else
        begin
            s_axi_arready_out <= ~ar_take & ~s_axi_rvalid_out;
            if (ar_take)
            begin
                s_axi_rvalid_out <= 1'b1;
                s_axi_rdata_out  <= {24'h00_0000, rd_byte};
                s_axi_rresp_out  <= mapped(ridx) ? `RXC_RESP_OKAY
                                                 : `RXC_RESP_SLVERR;
            end
            else if (s_axi_rvalid_out & s_axi_rready_in)
                s_axi_rvalid_out <= 1'b0;
        end
    end

endmodule // rxc_regs

`default_nettype wire

// ---- verif/rxc_regs_asserts.sv ----
// port assertions for the calibration register bank
`timescale 1ns/1ps
`default_nettype none
module rxc_regs_asserts (
    input wire logic        clk_in,
    input wire logic        sys_rst_in,
    input wire logic        s_axi_awvalid_in,
    input wire logic        s_axi_awready_out,
    input wire logic        s_axi_wvalid_in,
    input wire logic        s_axi_wready_out,
    input wire logic [1:0]  s_axi_bresp_out,
    input wire logic        s_axi_bvalid_out,
    input wire logic        s_axi_bready_in,
    input wire logic        s_axi_arvalid_in,
    input wire logic        s_axi_arready_out,
    input wire logic [31:0] s_axi_rdata_out,
    input wire logic        s_axi_rvalid_out,
    input wire logic        s_axi_rready_in,
    input wire logic [9:0]  i_channel_gain_trim_out,
    input wire logic [9:0]  q_channel_gain_trim_out
);
    // ********
    // helpers
    // ********
    // data takes over the last four cycles; a transfer must trace back to one of them
    logic [3:0] wr_hist_r;
    always_ff @(posedge clk_in or posedge sys_rst_in)
    begin
        if (sys_rst_in)
            wr_hist_r <= 4'h0;
        else
            wr_hist_r <= {wr_hist_r[2:0],
                          s_axi_wvalid_in && s_axi_wready_out};
    end
    default clocking @(posedge clk_in);
    endclocking
    default disable iff (sys_rst_in);
    // ********
    // properties
    // ********
    sequence s_wr_take;
        s_axi_awvalid_in && s_axi_awready_out
            && s_axi_wvalid_in && s_axi_wready_out;
    endsequence
    sequence s_rd_take;
        s_axi_arvalid_in && s_axi_arready_out;
    endsequence
    property p_b_answer;
        s_wr_take |-> ##[1:2] s_axi_bvalid_out;
    endproperty
    a_b_answer: assert property (p_b_answer)
        else $error("write response missing");
    property p_r_answer;
        s_rd_take |-> ##[1:2] s_axi_rvalid_out;
    endproperty
    a_r_answer: assert property (p_r_answer)
        else $error("read response missing");
    property p_b_hold;
        s_axi_bvalid_out && !s_axi_bready_in
            |=> s_axi_bvalid_out && $stable(s_axi_bresp_out);
    endproperty
    a_b_hold: assert property (p_b_hold)
        else $error("write response dropped");
    property p_b_done;
        s_axi_bvalid_out && s_axi_bready_in |=> !s_axi_bvalid_out;
    endproperty
    a_b_done: assert property (p_b_done)
        else $error("write response repeated");
    property p_r_hold;
        s_axi_rvalid_out && !s_axi_rready_in
            |=> s_axi_rvalid_out && $stable(s_axi_rdata_out);
    endproperty
    a_r_hold: assert property (p_r_hold)
        else $error("read data dropped");
    property p_r_upper;
        s_axi_rvalid_out |-> s_axi_rdata_out[31:8] == 24'h0;
    endproperty
    a_r_upper: assert property (p_r_upper)
        else $error("read data upper bits set");
    property p_aw_once;
        s_axi_awvalid_in && s_axi_awready_out |=> !s_axi_awready_out;
    endproperty
    a_aw_once: assert property (p_aw_once)
        else $error("address ready after take");
    property p_pend_block;
        s_axi_bvalid_out |-> !s_axi_awready_out && !s_axi_wready_out;
    endproperty
    a_pend_block: assert property (p_pend_block)
        else $error("ready while response pending");
    property p_trim_cause;
        $changed(i_channel_gain_trim_out)
            || $changed(q_channel_gain_trim_out) |-> wr_hist_r != 4'h0;
    endproperty
    a_trim_cause: assert property (p_trim_cause)
        else $error("trim changed without a write");
endmodule // rxc_regs_asserts
bind rxc_regs rxc_regs_asserts u_rxc_chk (
    .clk_in, .sys_rst_in, .s_axi_awvalid_in, .s_axi_awready_out,
    .s_axi_wvalid_in, .s_axi_wready_out, .s_axi_bresp_out,
    .s_axi_bvalid_out, .s_axi_bready_in, .s_axi_arvalid_in,
    .s_axi_arready_out, .s_axi_rdata_out, .s_axi_rvalid_out,
    .s_axi_rready_in, .i_channel_gain_trim_out, .q_channel_gain_trim_out
);
`default_nettype wire

// ---- verif/tb_top.sv ----
// self-checking bench for the calibration register bank
`timescale 1ns/1ps
`default_nettype none
`include "rxc_consts.vh"
module tb_top;
    logic        clk_in = 0;
    logic        sys_rst_in = 1;
    logic [11:0] awaddr = 0, araddr = 0;
    logic [31:0] wdata = 0, rdata, rdv;
    logic [3:0]  wstrb = 0;
    logic        awv = 0, wv = 0, bready = 0, arv = 0, rready = 0;
    logic        tx_lk = 1, rx_lk = 0;
    logic        awr, wrdy, bv, arr, rv, irq, fine, ien, qen, boff, pd, sgl;
    logic [1:0]  bresp, rresp, rr;
    logic [9:0]  it, qt, e_it, e_qt;
    logic [4:0]  fs, fsr;
    logic [10:0] e_bits;
    logic [7:0]  ih, il, qh, ql, ctl, pw;
    int          err_total = 0;
    int          tests_run = 0;
    wire  [10:0] o_bits = {fine, ien, qen, boff, fs, pd, sgl};
    always #4 clk_in = ~clk_in;
    rxc_regs dut (
        .clk_in(clk_in), .sys_rst_in(sys_rst_in),
        .s_axi_awaddr_in(awaddr), .s_axi_awvalid_in(awv),
        .s_axi_awready_out(awr), .s_axi_wdata_in(wdata),
        .s_axi_wstrb_in(wstrb), .s_axi_wvalid_in(wv),
        .s_axi_wready_out(wrdy), .s_axi_bresp_out(bresp),
        .s_axi_bvalid_out(bv), .s_axi_bready_in(bready),
        .s_axi_araddr_in(araddr), .s_axi_arvalid_in(arv),
        .s_axi_arready_out(arr), .s_axi_rdata_out(rdata),
        .s_axi_rresp_out(rresp), .s_axi_rvalid_out(rv),
        .s_axi_rready_in(rready), .tx_loop_lock_in(tx_lk),
        .rx_loop_lock_in(rx_lk), .i_channel_gain_trim_out(it),
        .q_channel_gain_trim_out(qt), .fine_trim_option_out(fine),
        .i_calibration_converter_enable_out(ien),
        .q_calibration_converter_enable_out(qen),
        .input_bias_buffer_off_out(boff), .full_scale_adjust_out(fs),
        .q_converter_power_down_out(pd),
        .single_converter_mode_out(sgl), .irq_out(irq)
    );
    // ********
    // tasks
    // ********
    task automatic end_of_test;
        $display("checks %0d mismatches %0d", tests_run, err_total);
        if (err_total == 0 && tests_run > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask
    task automatic chk(input logic [39:0] g, e, input string m);
        tests_run++;
        if (g !== e)
        begin
            err_total++;
            $display("mismatch at %0t: %s got %h exp %h", $time, m, g, e);
        end
    endtask
    // ready for the answer is raised a cycle late to exercise stalls
    task automatic wr(input logic [11:0] i, input logic [7:0] d,
                      input logic [1:0] er = 2'h0);
        int n;
        n = 0;
        @(posedge clk_in);
        awaddr <= i << 2;
        wdata <= 32'(d);
        wstrb <= 4'hf;
        awv <= 1;
        wv <= 1;
        do
        begin
            @(posedge clk_in);
            n++;
            if (awr) awv <= 0;
            if (wrdy) wv <= 0;
            if (bv && !bready) bready <= 1;
        end
        while (!(bv && bready) && n < 64);
        bready <= 0;
        chk({bv, bresp}, {1'b1, er}, "write response");
    endtask
    task automatic rd(input logic [11:0] i);
        int n;
        n = 0;
        @(posedge clk_in);
        araddr <= i << 2;
        arv <= 1;
        do
        begin
            @(posedge clk_in);
            n++;
            if (arr) arv <= 0;
            if (rv && !rready) rready <= 1;
        end
        while (!(rv && rready) && n < 64);
        rdv = rdata;
        rr = rresp;
        rready <= 0;
        chk(rv, 1, "read response");
    endtask
    task automatic rdc(input logic [11:0] i, input logic [31:0] e);
        rd(i);
        chk({rr, rdv}, {2'h0, e}, "read data");
    endtask
    task automatic settle;
        repeat (4) @(posedge clk_in);
        #1;
    endtask
    task automatic xfer;
        wr(`RXC_IDX_TRIGGER, 8'h01);
        settle;
    endtask
    task automatic outs(input string m);
        chk({it, qt, o_bits}, {e_it, e_qt, e_bits}, m);
    endtask
    function automatic logic [9:0] exp_trim(input logic [7:0] h, l,
                                            input logic en);
        return en ? {h, l[2:1]} : 10'h000;
    endfunction
    // ********
    // sequence
    // ********
    initial
    begin
        #160_000;
        err_total++;
        end_of_test;
    end
    initial
    begin
        {e_it, e_qt, e_bits} = 0;
        void'($urandom(32'hf526_1bc4));
        repeat (16) @(posedge clk_in);
        sys_rst_in <= 0;
        settle;
        chk({irq, it, qt, o_bits}, 0, "reset outputs");
        rdc(`RXC_IDX_TRIMCTRL, 0);
        rdc(`RXC_IDX_LOCK, 2);
        rd(12'h003);
        chk({rr, rdv}, {`RXC_RESP_SLVERR, 32'h0}, "unmapped read");
        wr(12'h003, 8'h5a, `RXC_RESP_SLVERR);
        @(posedge clk_in);
        rx_lk <= 1;
        settle;
        rdc(`RXC_IDX_LOCK, 3);
        $display("test reset and map done");
        for (int k = 0; k < 6; k++)
        begin
            {ih, il, qh, ql} = $urandom;
            {ctl, pw, fsr} = 21'($urandom);
            if (k == 1) {ih, il, qh, ql} = 32'hff07_0006;
            ctl = ctl & 8'h61;
            ctl[6] = (k != 0);
            wr(`RXC_IDX_IHIGH, ih);
            wr(`RXC_IDX_ILOW, il);
            wr(`RXC_IDX_QHIGH, qh);
            wr(`RXC_IDX_QLOW, ql);
            wr(`RXC_IDX_TRIMCTRL, ctl);
            wr(`RXC_IDX_FSADJ, 8'(fsr));
            wr(`RXC_IDX_PWRCTRL, pw & 8'h03);
            rdc(`RXC_IDX_IHIGH, 32'(ih));
            rdc(`RXC_IDX_QLOW, 32'(ql[2:0]));
            outs("held before transfer");
            e_it = exp_trim(ih, il, ctl[6]);
            e_qt = exp_trim(qh, ql, ctl[6]);
            e_bits = {ctl[5], il[0], ql[0], ctl[0], fsr, pw[0], pw[1]};
            xfer;
            outs("after transfer");
            wr(`RXC_IDX_TRIGGER, 8'h00);
        end
        $display("test transfers done");
        xfer;
        wr(`RXC_IDX_IHIGH, ~ih);
        xfer;
        outs("trigger held high");
        wr(`RXC_IDX_TRIGGER, 8'h00);
        settle;
        outs("trigger cleared");
        xfer;
        e_it = exp_trim(~ih, il, 1'b1);
        outs("trigger rearmed");
        $display("test trigger edge done");
        wr(`RXC_IDX_IRQSTAT, 8'h07);
        rdc(`RXC_IDX_IRQSTAT, 0);
        wr(`RXC_IDX_IRQMASK, 8'h01);
        chk(irq, 0, "irq idle");
        wr(`RXC_IDX_TRIGGER, 8'h00);
        xfer;
        chk(irq, 1, "irq on transfer");
        @(posedge clk_in);
        rx_lk <= 0;
        settle;
        rdc(`RXC_IDX_IRQSTAT, 3);
        rdc(`RXC_IDX_LOCK, 2);
        wr(`RXC_IDX_IRQSTAT, 8'h01);
        settle;
        chk(irq, 0, "irq masked");
        wr(`RXC_IDX_IRQMASK, 8'h02);
        settle;
        chk(irq, 1, "irq unmasked");
        wr(`RXC_IDX_IRQSTAT, 8'h02);
        settle;
        chk(irq, 0, "irq cleared");
        @(posedge clk_in);
        tx_lk <= 0;
        settle;
        rdc(`RXC_IDX_IRQSTAT, 4);
        rdc(`RXC_IDX_LOCK, 0);
        $display("test interrupts done");
        end_of_test;
    end
endmodule // tb_top
`default_nettype wire
